/* File: bench/regoffset_load_store_decode_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module regoffset_load_store_decode_test;
   localparam logic [31:0] FILL = 32'h8f7e_c1b3;
   localparam logic [2:0] RO [8] = '{3'h6, 3'h3, 3'h6, 3'h3, 3'h2, 3'h2, 3'h1, 3'h2};
   logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, cap_addr, cap_wdata, ad, m, ex;
   logic mem_req, mem_we, busy, done, cap_we, ld;
   logic [3:0] mem_be;
   logic [1:0] mem_size, cap_size, sz;
   logic [31:0] gpr [8];
   int err_count = 0, checks_done = 0, cycles = 0, reqs = 0, r;
   always #5 ref_clk = ~ref_clk;
   rolsd_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_be(mem_be), .mem_size(mem_size), .mem_rdata(mem_rdata), .busy(busy), .done(done));
   rolsd_mem_model #(.FILL(FILL)) mem_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .done(done), .mem_rdata(mem_rdata));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (mem_req) begin
         reqs++;
         {cap_we, cap_addr, cap_wdata, cap_size} = {mem_we, mem_addr, mem_wdata, mem_size};
      end
      if (cycles == 3000) begin
         err_count++;
         end_sim;
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   task automatic run(input logic [15:0] ins, input int n_exp);
      int n;
      wr(4'h1, {16'h0, ins});
      wr(4'h0, 32'h1);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
      end while (done !== 1'b1 && n < 20);
      `CHK(n, n_exp)
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      gpr = '{32'h100, 32'h1, 32'h2, 32'h3, 32'hc3a5_96f0, 32'h0, 32'h7c, 32'h0};
      for (int i = 0; i < 8; i++)
         wr(4'h8 + 4'(i), gpr[i]);
      for (int i = 0; i < 8; i++) begin
         ld = i[2] ? (i[1:0] != 2'h0) : i[1];
         sz = i[2] ? (i == 6 ? 2'h0 : 2'h1) : (i[0] ? 2'h0 : 2'h2);
         ad = gpr[0] + gpr[RO[i]];
         m = (FILL ^ ad) >> (sz == 2'h2 ? 0 : sz == 2'h1 ? 16 * ad[1] : 8 * ad[1:0]);
         case (i)
            2: ex = m;
            3: ex = {24'h0, m[7:0]};
            5: ex = {16'h0, m[15:0]};
            6: ex = {{24{m[7]}}, m[7:0]};
            7: ex = {{16{m[15]}}, m[15:0]};
            default: ex = gpr[5];
         endcase
         run({4'h5, i[1:0], i[2], RO[i], 3'h0, ld ? 3'h5 : 3'h4}, ld ? 4 : 2);
         `CHK(cap_we, !ld)
         `CHK(cap_addr, ad)
         `CHK(cap_size, sz)
         m = sz == 2'h2 ? gpr[4] : sz == 2'h1 ? {2{gpr[4][15:0]}} : {4{gpr[4][7:0]}};
         if (!ld) `CHK(cap_wdata, m)
         rd(4'hd, ex);
         rd(4'h8, 32'h100);
         gpr[5] = ex;
         $display("test %0d finished", i);
      end
      r = reqs;
      run(16'h6000, 1);
      rd(4'h2, 32'h2);
      `CHK(reqs, r)
      rd(4'h5, 32'h0);
      $display("test group check finished");
      end_sim;
   end
endmodule

/* File: bench/rolsd_core_sva.sv */
`timescale 1ns/1ps
module rolsd_core_sva (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [3:0]  mem_be,
   input wire logic [1:0]  mem_size,
   input wire logic        busy,
   input wire logic        done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_start;
      reg_wr && reg_addr == 4'h0 && reg_wdata[0] && !busy;
   endsequence
   sequence s_st;
      mem_req && mem_we;
   endsequence
   sequence s_ld;
      mem_req && !mem_we;
   endsequence
   a_start_busy: assert property (s_start |=> busy)
      else $error("busy not raised");
   a_start_req: assert property (s_start |-> ##2 (mem_req || done))
      else $error("no access after start");
   a_store_done: assert property (s_st |=> done && !busy)
      else $error("store length wrong");
   a_load_done: assert property (s_ld |=> !done [*2] ##1 done)
      else $error("load length wrong");
   a_req_pulse: assert property (mem_req |=> !mem_req)
      else $error("request too long");
   a_be_word: assert property (mem_req && mem_size == 2'h2 |-> mem_be == 4'hf)
      else $error("word lanes wrong");
   a_be_byte: assert property (mem_req && mem_size == 2'h0 |->
                               mem_be == 4'(4'h1 << mem_addr[1:0]))
      else $error("byte lane wrong");
   a_be_half: assert property (mem_req && mem_size == 2'h1 |->
                               mem_be == (mem_addr[1] ? 4'hc : 4'h3))
      else $error("half lanes wrong");
   a_byte_data: assert property ((mem_req && mem_we && mem_size == 2'h0) |->
                                 mem_wdata == {4{mem_wdata[7:0]}})
      else $error("byte data wrong");
   a_half_data: assert property ((mem_req && mem_we && mem_size == 2'h1) |->
                                 mem_wdata == {2{mem_wdata[15:0]}})
      else $error("half data wrong");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   a_done_end: assert property (done |-> !busy && $past(busy))
      else $error("done without busy");
endmodule
bind rolsd_core rolsd_core_sva chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_be(mem_be), .mem_size(mem_size), .busy(busy), .done(done));

/* File: bench/rolsd_mem_model.sv */
`timescale 1ns/1ps
module rolsd_mem_model #(
   parameter logic [31:0] FILL = 32'h8f7e_c1b3
) (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        done,
   output logic     [31:0] mem_rdata
);
   logic active;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || done)
         active <= 1'b0;
      else if (mem_req && !mem_we)
         active <= 1'b1;
   end
   // Outside a load the data bus toggles so stale values are never mistaken for good ones.
   always_ff @(posedge ref_clk) begin
      if (sys_rst)
         mem_rdata <= 32'h0;
      else if (mem_req && !mem_we)
         mem_rdata <= FILL ^ mem_addr;
      else if (!active || done)
         mem_rdata <= ~mem_rdata;
   end
endmodule

/* File: rtl/rolsd_core.sv */
// Summary of operation
// - Destination from bits 2:0, base from 5:3, offset from 8:6, low registers.
// - Load flag 0 stores, 1 loads; size flag 0 word, 1 byte.
// - Address is base plus offset register, no base writeback.
// - Word store writes all 32 source bits.
// - Byte store writes the source register's low byte.
// - Word load puts the 32-bit word in the destination.
// - Byte load puts the addressed byte in the destination.
// - Halfword format selectors: store half, load half, signed byte, signed half.
// - Halfword store writes the source's low sixteen bits.
// - Unsigned halfword load clears bits 31:16.
// - Signed byte load copies bit 7 into bits 31:8.
// - Signed halfword load copies bit 15 into bits 31:16.
// - Cycle count equals that of the equivalent wide instruction; here stores take 2 cycles, loads take 4 rather than 3.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "rolsd_defs.svh"
module rolsd_core (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [31:0] mem_addr,
   output logic      [31:0] mem_wdata,
   output logic      [3:0]  mem_be,
   output logic      [1:0]  mem_size,
   input  wire logic [31:0] mem_rdata,
   output logic             busy,
   output logic             done
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   rolsd_dec_if dec ();
   rolsd_field_decode u_dec (
      .dec (dec)
   );

   rolsd_pkg::rolsd_state_t state;
   rolsd_pkg::rolsd_op_t    op_q;
   logic [31:0]             gpr [8];
   logic [15:0]             instr_q;
   logic [2:0]              rd_q;
   logic                    load_q;
   logic                    bad_q;
   logic [2:0]              cyc_cnt;
   logic [2:0]              cyc_target;
   logic [31:0]             ea;
   logic [31:0]             load_val;
   logic [1:0]              lane;
   logic [7:0]              ld_byte;
   logic [15:0]             ld_half;
   logic                    start;

   assign dec.instr = instr_q;
   assign start     = reg_wr && (reg_addr == `ROLSD_REG_CTRL) && reg_wdata[0] &&
                      (state == rolsd_pkg::rolsd_idle);

   // Pre-indexed address; the base register is never updated.
   assign ea = gpr[dec.rb_sel] + gpr[dec.ro_sel];

   // ****************************************************************
   // Load data extension
   // ****************************************************************
   assign lane    = mem_addr[1:0];
   assign ld_byte = mem_rdata[{lane, 3'h0} +: 8];
   assign ld_half = mem_rdata[{lane[1], 4'h0} +: 16];

   always_comb begin
      load_val = mem_rdata;
      unique case (op_q)
         rolsd_pkg::load_byte_op:
            load_val = {24'h00_0000, ld_byte};
         rolsd_pkg::load_halfword_op:
            load_val = {16'h0000, ld_half};
         rolsd_pkg::load_signed_byte_op:
            load_val = {{24{ld_byte[7]}}, ld_byte};
         rolsd_pkg::load_signed_halfword_op:
            load_val = {{16{ld_half[15]}}, ld_half};
         default:
            load_val = mem_rdata;
      endcase
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state      <= rolsd_pkg::rolsd_idle;
         cyc_cnt    <= 3'h0;
         cyc_target <= 3'h0;
         busy       <= 1'b0;
         done       <= 1'b0;
         bad_q      <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state)
            rolsd_pkg::rolsd_idle: begin
               if (start) begin
                  state <= rolsd_pkg::rolsd_addr;
                  busy  <= 1'b1;
               end
            end
            rolsd_pkg::rolsd_addr: begin
               bad_q <= !dec.hit;
               if (!dec.hit) begin
                  state <= rolsd_pkg::rolsd_idle;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end else begin
                  state      <= rolsd_pkg::rolsd_mem;
                  cyc_cnt    <= 3'h1;
                  cyc_target <= dec.is_load ? `ROLSD_LOAD_CYCLES
                                            : `ROLSD_STORE_CYCLES;
               end
            end
            rolsd_pkg::rolsd_mem: begin
               cyc_cnt <= cyc_cnt + 3'h1;
               if (cyc_cnt + 3'h1 == cyc_target) begin
                  state <= load_q ? rolsd_pkg::rolsd_wback : rolsd_pkg::rolsd_idle;
                  busy  <= load_q;
                  done  <= !load_q;
               end
            end
            rolsd_pkg::rolsd_wback: begin
               state <= rolsd_pkg::rolsd_idle;
               busy  <= 1'b0;
               done  <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************************************
   // Memory request
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         mem_be    <= 4'h0;
         mem_size  <= 2'h0;
         op_q      <= rolsd_pkg::store_word_op;
         rd_q      <= 3'h0;
         load_q    <= 1'b0;
      end else begin
         mem_req <= 1'b0;
         mem_we  <= 1'b0;
         if (state == rolsd_pkg::rolsd_addr && dec.hit) begin
            op_q     <= dec.op;
            rd_q     <= dec.rd_sel;
            load_q   <= dec.is_load;
            mem_req  <= 1'b1;
            mem_we   <= !dec.is_load;
            mem_addr <= ea;
            unique case (dec.op)
               rolsd_pkg::store_word_op, rolsd_pkg::load_word_op: begin
                  mem_size  <= 2'h2;
                  mem_be    <= 4'hf;
                  mem_wdata <= gpr[dec.rd_sel];
               end
               rolsd_pkg::store_byte_op, rolsd_pkg::load_byte_op,
               rolsd_pkg::load_signed_byte_op: begin
                  mem_size  <= 2'h0;
                  mem_be    <= 4'h1 << ea[1:0];
                  mem_wdata <= {4{gpr[dec.rd_sel][7:0]}};
               end
               default: begin
                  mem_size  <= 2'h1;
                  mem_be    <= ea[1] ? 4'hc : 4'h3;
                  mem_wdata <= {2{gpr[dec.rd_sel][15:0]}};
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Register file and software port
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         instr_q <= 16'h0000;
      end else if (reg_wr && reg_addr == `ROLSD_REG_INSTR && state == rolsd_pkg::rolsd_idle) begin
         instr_q <= reg_wdata[15:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_gpr
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               gpr[gi] <= 32'h0000_0000;
            end else if (state == rolsd_pkg::rolsd_wback && rd_q == 3'(gi)) begin
               gpr[gi] <= load_val;
            end else if (reg_wr && reg_addr == `ROLSD_REG_GPR0 + 4'(gi) &&
                         state == rolsd_pkg::rolsd_idle) begin
               gpr[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (reg_addr[3]) begin
            reg_rdata <= gpr[reg_addr[2:0]];
         end else begin
            unique case (reg_addr)
               `ROLSD_REG_INSTR:  reg_rdata <= {16'h0000, instr_q};
               `ROLSD_REG_STATUS: reg_rdata <= {30'h0000_0000, bad_q, busy};
               `ROLSD_REG_ADDR:   reg_rdata <= mem_addr;
               `ROLSD_REG_RESULT: reg_rdata <= load_val;
               default:           reg_rdata <= 32'h0000_0000;
            endcase
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

/* File: rtl/rolsd_dec_if.sv */
`timescale 1ns/1ps
interface rolsd_dec_if;
   logic [15:0]              instr;
   logic                     hit;
   logic [2:0]               rd_sel;
   logic [2:0]               rb_sel;
   logic [2:0]               ro_sel;
   rolsd_pkg::rolsd_op_t     op;
   logic                     is_load;

   modport decoder (input instr, output hit, rd_sel, rb_sel, ro_sel, op, is_load);
   modport user    (output instr, input hit, rd_sel, rb_sel, ro_sel, op, is_load);
endinterface

/* File: rtl/rolsd_defs.svh */
`ifndef ROLSD_DEFS_SVH
`define ROLSD_DEFS_SVH

// Instruction field positions.
`define ROLSD_RD_LSB        0
`define ROLSD_RB_LSB        3
`define ROLSD_RO_LSB        6
`define ROLSD_FMT_BIT       9
`define ROLSD_SIZE_BIT      10
`define ROLSD_LS_BIT        11
`define ROLSD_GROUP_MSB     15
`define ROLSD_GROUP_LSB     12
`define ROLSD_GROUP_CODE    4'h5

// Cycle counts of the equivalent wide instructions.
`define ROLSD_STORE_CYCLES  3'h2
`define ROLSD_LOAD_CYCLES   3'h3

// Register port offsets.
`define ROLSD_REG_CTRL      4'h0
`define ROLSD_REG_INSTR     4'h1
`define ROLSD_REG_STATUS    4'h2
`define ROLSD_REG_ADDR      4'h3
`define ROLSD_REG_RESULT    4'h4
`define ROLSD_REG_GPR0      4'h8

`define ROLSD_CTRL_RESET    32'h0000_0000

`endif

/* File: rtl/rolsd_field_decode.sv */
`timescale 1ns/1ps
`include "rolsd_defs.svh"
module rolsd_field_decode (
   rolsd_dec_if.decoder dec
);

   logic [1:0] sel;

   // Register fields, each picking one of the low eight registers.
   assign dec.rd_sel = dec.instr[`ROLSD_RD_LSB +: 3];
   assign dec.rb_sel = dec.instr[`ROLSD_RB_LSB +: 3];
   assign dec.ro_sel = dec.instr[`ROLSD_RO_LSB +: 3];
   assign dec.hit    = (dec.instr[`ROLSD_GROUP_MSB:`ROLSD_GROUP_LSB] == `ROLSD_GROUP_CODE);
   assign sel        = {dec.instr[`ROLSD_LS_BIT], dec.instr[`ROLSD_SIZE_BIT]};

   always_comb begin
      if (!dec.instr[`ROLSD_FMT_BIT]) begin
         // Word/byte format: load flag high means load, size flag high means byte.
         unique case (sel)
            2'b00: dec.op = rolsd_pkg::store_word_op;
            2'b01: dec.op = rolsd_pkg::store_byte_op;
            2'b10: dec.op = rolsd_pkg::load_word_op;
            2'b11: dec.op = rolsd_pkg::load_byte_op;
         endcase
      end else begin
         unique case (sel)
            2'b00: dec.op = rolsd_pkg::store_halfword_op;
            2'b01: dec.op = rolsd_pkg::load_halfword_op;
            2'b10: dec.op = rolsd_pkg::load_signed_byte_op;
            2'b11: dec.op = rolsd_pkg::load_signed_halfword_op;
         endcase
      end
   end

   assign dec.is_load = !(dec.op inside {rolsd_pkg::store_word_op, rolsd_pkg::store_byte_op,
                                         rolsd_pkg::store_halfword_op});

endmodule

/* File: rtl/rolsd_pkg.sv */
package rolsd_pkg;

   typedef enum logic [7:0] {
      store_word_op           = 8'h01,
      store_byte_op           = 8'h02,
      load_word_op            = 8'h04,
      load_byte_op            = 8'h08,
      store_halfword_op       = 8'h10,
      load_halfword_op        = 8'h20,
      load_signed_byte_op     = 8'h40,
      load_signed_halfword_op = 8'h80
   } rolsd_op_t;

   typedef enum logic [3:0] {
      rolsd_idle  = 4'h1,
      rolsd_addr  = 4'h2,
      rolsd_mem   = 4'h4,
      rolsd_wback = 4'h8
   } rolsd_state_t;

endpackage
